// file: hw/fpve_arb_if.sv
// Candidate vectors and winner between decoder and arbiter
`timescale 1ns/1ns
interface fpve_arb_if;
    logic       mc_vld;     // Memory controller candidate present
    logic [7:0] mc_vec;     // Memory controller candidate vector
    logic       sb_vld;     // System bus candidate present
    logic [7:0] sb_vec;     // System bus candidate vector
    logic       bd_vld;     // Board candidate present
    logic [7:0] bd_vec;     // Board candidate vector
    logic       win_vld;    // Some candidate present
    logic [7:0] win_vec;    // Highest candidate vector

    modport src (output mc_vld, mc_vec, sb_vld, sb_vec, bd_vld, bd_vec,
                 input  win_vld, win_vec);
    modport arb (input  mc_vld, mc_vec, sb_vld, sb_vec, bd_vld, bd_vec,
                 output win_vld, win_vec);
endinterface

// file: hw/fpve_arbiter.sv
// Fixed-priority pick among the three candidate vectors
`timescale 1ns/1ns
module fpve_arbiter (
    fpve_arb_if.arb ab     // Candidates in, winner out
);
    import fpve_pkg::*;

    // ========================================================================
    // Pick
    // ========================================================================
    logic [8:0] best;      // Valid bit on top of vector

    // Pure combination: nothing is held, a dropped request leaves at once
    always_comb begin
        best = pick_max({ab.mc_vld, ab.mc_vec}, {ab.sb_vld, ab.sb_vec});
        best = pick_max(best, {ab.bd_vld, ab.bd_vec});
    end

    assign ab.win_vld = best[8];
    assign ab.win_vec = best[8] ? best[7:0] : VEC_RST;

endmodule

// file: hw/fpve_pkg.sv
// Shared constants, codes and vector helpers for the priority vector encoder
package fpve_pkg;

    // ========================================================================
    // Widths and reset values
    // ========================================================================
    localparam int         CODE_W      = 4;       // Encoded chip request width
    localparam int         VEC_W       = 8;       // Processor vector bus width
    localparam int         LINE_N      = 8;       // Board request lines
    localparam logic [7:0] VEC_RST     = 8'h00;   // Vector shown while idle
    localparam logic       PEND_RST    = 1'b0;    // No request after reset

    // ========================================================================
    // Vectors of the fixed sources
    // ========================================================================
    localparam logic [7:0] VEC_WDOG    = 8'hff;   // Watchdog timeout, level 31
    localparam logic [7:0] VEC_ECC_MB  = 8'hfe;   // Multi-bit memory error
    localparam logic [7:0] VEC_NMI     = 8'hfd;   // System bus non-maskable
    localparam logic [7:0] VEC_BSEV    = 8'hf8;   // Board severe error
    localparam logic [7:0] VEC_LB_EXC  = 8'hf3;   // Local bus exception
    localparam logic [7:0] VEC_LB_PAR  = 8'hf2;   // Local bus parity error
    localparam logic [7:0] VEC_LB_PM   = 8'hf1;   // Parity, processor master
    localparam logic [7:0] VEC_BERR    = 8'hf0;   // Board ordinary error
    localparam logic [7:0] VEC_MP_CPU  = 8'heb;   // Protect, processor master
    localparam logic [7:0] VEC_MP_SLV  = 8'hea;   // Protect, bus slave access
    localparam logic [7:0] VEC_DBG_RX  = 8'hd1;   // Debug port receive
    localparam logic [7:0] VEC_DBG_TX  = 8'hd0;   // Debug port transmit
    localparam logic [7:0] VEC_ATTN    = 8'h64;   // Control block attention
    localparam logic [7:0] VEC_XEND    = 8'h63;   // Bus master transfer end
    localparam logic [7:0] VEC_GEN     = 8'h62;   // General interrupt
    localparam logic [7:0] VEC_BM_CH2  = 8'h61;   // Bus master channel 2
    localparam logic [7:0] VEC_BM_CH1  = 8'h60;   // Bus master channel 1
    localparam logic [7:0] VEC_TMR1    = 8'h23;   // Interval timer 1
    localparam logic [7:0] VEC_TMR2    = 8'h22;   // Interval timer 2
    localparam logic [7:0] VEC_TMR3    = 8'h21;   // Interval timer 3
    localparam logic [7:0] VEC_TMR4    = 8'h20;   // Interval timer 4
    localparam logic [7:0] VEC_ECC_SB  = 8'h08;   // Single-bit error, lowest

    // ========================================================================
    // Request codes of the memory controller chip (0 means idle)
    // ========================================================================
    localparam logic [3:0] MC_WDOG     = 4'h1;    // Timer 0 / watchdog
    localparam logic [3:0] MC_ECC_MB   = 4'h2;    // Multi-bit error
    localparam logic [3:0] MC_LB_EXC   = 4'h3;    // Local bus exception
    localparam logic [3:0] MC_LB_PAR   = 4'h4;    // Local bus parity
    localparam logic [3:0] MC_LB_PM    = 4'h5;    // Parity, processor master
    localparam logic [3:0] MC_MP_CPU   = 4'h6;    // Protect, processor
    localparam logic [3:0] MC_MP_SLV   = 4'h7;    // Protect, slave access
    localparam logic [3:0] MC_TMR1     = 4'h8;    // Timer 1
    localparam logic [3:0] MC_TMR2     = 4'h9;    // Timer 2
    localparam logic [3:0] MC_TMR3     = 4'ha;    // Timer 3
    localparam logic [3:0] MC_TMR4     = 4'hb;    // Timer 4
    localparam logic [3:0] MC_ECC_SB   = 4'hc;    // Single-bit error

    // ========================================================================
    // Request codes of the system bus interface chip (0 means idle)
    // ========================================================================
    localparam logic [3:0] SB_NMI      = 4'h1;    // Non-maskable command
    localparam logic [3:0] SB_DBG_RX   = 4'h2;    // Debug receive
    localparam logic [3:0] SB_DBG_TX   = 4'h3;    // Debug transmit
    localparam logic [3:0] SB_ATTN     = 4'h4;    // Attention port
    localparam logic [3:0] SB_XEND     = 4'h5;    // Transfer end
    localparam logic [3:0] SB_GEN      = 4'h6;    // General interrupt
    localparam logic [3:0] SB_BM_CH2   = 4'h7;    // Channel 2
    localparam logic [3:0] SB_BM_CH1   = 4'h8;    // Channel 1

    // Board line vectors in direct mode, index is the line number
    localparam logic [7:0] LINE_VEC [LINE_N] = '{
        8'hd8, 8'hd9, 8'hda, 8'hdb, 8'he0, 8'he8, VEC_BERR, VEC_BSEV};

    // ========================================================================
    // Helpers
    // ========================================================================
    // True for vectors that a source may raise; platform reserves the rest
    function automatic logic vec_legal(input logic [7:0] v);
        vec_legal = v inside {VEC_WDOG, VEC_ECC_MB, VEC_NMI, VEC_BSEV,
            [VEC_BERR:VEC_LB_EXC], VEC_MP_CPU, VEC_MP_SLV, 8'he8, 8'he0,
            [8'hd8:8'hdb], VEC_DBG_RX, VEC_DBG_TX, [8'h80:8'hcf],
            8'h7b, 8'h7c, 8'h78, [8'h70:8'h74], [VEC_BM_CH1:VEC_ATTN],
            [8'h40:8'h53], 8'h3a, [VEC_TMR4:VEC_TMR1], VEC_ECC_SB};
    endfunction

    // Higher vector number is the higher fixed priority
    function automatic logic [8:0] pick_max(input logic [8:0] a,
                                            input logic [8:0] b);
        if (!a[8])
            pick_max = b;
        else if (b[8] && b[7:0] > a[7:0])
            pick_max = b;
        else
            pick_max = a;
    endfunction

endpackage

// file: hw/fpve_top.sv
// Fixed-priority interrupt vector encoder for the processor interrupt bus
`timescale 1ns/1ns
module fpve_top
    import fpve_pkg::*;
(
    input  wire logic                          CLK,        // 20 MHz clock
    input  wire logic                          RST_N,      // Async reset
    input  wire logic [fpve_pkg::CODE_W-1:0]   SBI_CODE,   // Sys bus code
    input  wire logic [fpve_pkg::CODE_W-1:0]   MC_CODE,    // Mem ctrl code
    input  wire logic [fpve_pkg::LINE_N-1:0]   BOARD_LINES,// Lines or vector
    input  wire logic                          BOARD_VREQ, // Vectored request
    input  wire logic                          BOARD_INT_ENABLE, // Board gate
    input  wire logic                          BOARD_VECTOR_MODE_SELECT,// Mode
    output logic      [fpve_pkg::VEC_W-1:0]    INT_VEC,    // Vector bus
    output logic                               INT_PEND    // Request pending
);

    // ========================================================================
    // Input synchronisers
    // ========================================================================
    localparam int IN_W = 2 * CODE_W + LINE_N + 3;   // All pin inputs

    logic [IN_W-1:0] meta_q,  meta_d;     // First stage, read by stage two
    logic [IN_W-1:0] sync_q,  sync_d;     // Second stage, safe to decode

    // All pins arrive from other chips, so two flops before any decode
    always_comb begin
        meta_d = {SBI_CODE, MC_CODE, BOARD_LINES, BOARD_VREQ,
                  BOARD_INT_ENABLE, BOARD_VECTOR_MODE_SELECT};
        sync_d = meta_q;
    end

    // Register both stages
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    // Unpack the synchronised inputs
    logic [3:0] sb_code;   // System bus code
    logic [3:0] mc_code;   // Memory controller code
    logic [7:0] bd_lines;  // Board lines or board vector
    logic       bd_vreq;   // Board vectored request
    logic       bd_en;     // Board interrupt gate
    logic       bd_vmode;  // Board vectored mode

    assign {sb_code, mc_code, bd_lines, bd_vreq, bd_en, bd_vmode} = sync_q;

    // ========================================================================
    // Source decode
    // ========================================================================
    fpve_arb_if arb_bus ();   // Candidates to arbiter

    // Memory controller code to vector; unused codes mean no request
    always_comb begin
        arb_bus.mc_vld = 1'b1;
        case (mc_code)
            MC_WDOG:   arb_bus.mc_vec = VEC_WDOG;
            MC_ECC_MB: arb_bus.mc_vec = VEC_ECC_MB;
            MC_LB_EXC: arb_bus.mc_vec = VEC_LB_EXC;
            MC_LB_PAR: arb_bus.mc_vec = VEC_LB_PAR;
            MC_LB_PM:  arb_bus.mc_vec = VEC_LB_PM;
            MC_MP_CPU: arb_bus.mc_vec = VEC_MP_CPU;
            MC_MP_SLV: arb_bus.mc_vec = VEC_MP_SLV;
            MC_TMR1:   arb_bus.mc_vec = VEC_TMR1;
            MC_TMR2:   arb_bus.mc_vec = VEC_TMR2;
            MC_TMR3:   arb_bus.mc_vec = VEC_TMR3;
            MC_TMR4:   arb_bus.mc_vec = VEC_TMR4;
            MC_ECC_SB: arb_bus.mc_vec = VEC_ECC_SB;
            default: begin
                arb_bus.mc_vld = 1'b0;
                arb_bus.mc_vec = VEC_RST;
            end
        endcase
    end

    // System bus code to vector; unused codes mean no request
    always_comb begin
        arb_bus.sb_vld = 1'b1;
        case (sb_code)
            SB_NMI:    arb_bus.sb_vec = VEC_NMI;
            SB_DBG_RX: arb_bus.sb_vec = VEC_DBG_RX;
            SB_DBG_TX: arb_bus.sb_vec = VEC_DBG_TX;
            SB_ATTN:   arb_bus.sb_vec = VEC_ATTN;
            SB_XEND:   arb_bus.sb_vec = VEC_XEND;
            SB_GEN:    arb_bus.sb_vec = VEC_GEN;
            SB_BM_CH2: arb_bus.sb_vec = VEC_BM_CH2;
            SB_BM_CH1: arb_bus.sb_vec = VEC_BM_CH1;
            default: begin
                arb_bus.sb_vld = 1'b0;
                arb_bus.sb_vec = VEC_RST;
            end
        endcase
    end

    // Board candidate: highest active line, or the board's own vector
    logic [8:0] line_best;    // Best direct-mode line, valid on top

    always_comb begin
        line_best = '0;
        for (int i = 0; i < LINE_N; i++) begin
            if (bd_lines[i])
                line_best = pick_max(line_best, {1'b1, LINE_VEC[i]});
        end
        arb_bus.bd_vld = 1'b0;
        arb_bus.bd_vec = VEC_RST;
        if (bd_en) begin
            if (bd_vmode) begin
                // A reserved vector from the board is dropped, not passed
                arb_bus.bd_vld = bd_vreq && vec_legal(bd_lines);
                arb_bus.bd_vec = bd_lines;
            end else begin
                arb_bus.bd_vld = line_best[8];
                arb_bus.bd_vec = line_best[7:0];
            end
        end
    end

    // ========================================================================
    // Arbitration and output register
    // ========================================================================
    fpve_arbiter u_arb (
        .ab (arb_bus.arb)
    );

    logic [7:0] vec_q,  vec_d;    // Vector bus register
    logic       pend_q, pend_d;   // Pending flag register

    // Follow the winner every cycle; no request is held here
    always_comb begin
        vec_d  = arb_bus.win_vec;
        pend_d = arb_bus.win_vld;
    end

    // Register outputs so the bus never shows decode glitches
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            vec_q  <= VEC_RST;
            pend_q <= PEND_RST;
        end else begin
            vec_q  <= vec_d;
            pend_q <= pend_d;
        end
    end

    assign INT_VEC  = vec_q;
    assign INT_PEND = pend_q;

    // ========================================================================
    // Checks: a pin level held three cycles shows at the fourth
    // ========================================================================
    property p_wdog_top;
        @(posedge CLK) disable iff (!RST_N)
        (MC_CODE == MC_WDOG)[*3] |=> (INT_PEND && INT_VEC == VEC_WDOG);
    endproperty
    a_wdog_top: assert property (p_wdog_top)
        else $error("watchdog not shown as FF");

    property p_idle;
        @(posedge CLK) disable iff (!RST_N)
        (MC_CODE == 4'h0 && SBI_CODE == 4'h0 && !BOARD_INT_ENABLE)[*3]
        |=> (!INT_PEND && INT_VEC == VEC_RST);
    endproperty
    a_idle: assert property (p_idle)
        else $error("pending shown with no enabled source");

    property p_single_low;
        @(posedge CLK) disable iff (!RST_N)
        // Board gated off, else a board vector may rightly win
        (MC_CODE == MC_ECC_SB && SBI_CODE == SB_BM_CH1 &&
         !BOARD_INT_ENABLE)[*3]
        |=> (INT_VEC == VEC_BM_CH1);
    endproperty
    a_single_low: assert property (p_single_low)
        else $error("single-bit error beat a higher source");

    property p_attn;
        @(posedge CLK) disable iff (!RST_N)
        (SBI_CODE == SB_ATTN && MC_CODE == MC_TMR1 && !BOARD_INT_ENABLE)[*3]
        |=> (INT_VEC == VEC_ATTN);
    endproperty
    a_attn: assert property (p_attn)
        else $error("attention vector wrong");

    property p_direct;
        @(posedge CLK) disable iff (!RST_N)
        (MC_CODE == MC_LB_EXC && SBI_CODE == 4'h0 && BOARD_INT_ENABLE &&
         !BOARD_VECTOR_MODE_SELECT && BOARD_LINES == 8'hc1)[*3]
        |=> (INT_VEC == VEC_BSEV);
    endproperty
    a_direct: assert property (p_direct)
        else $error("direct line seven not winning as F8");

    property p_vectored;
        @(posedge CLK) disable iff (!RST_N)
        (MC_CODE == MC_TMR2 && SBI_CODE == 4'h0 && BOARD_INT_ENABLE &&
         BOARD_VECTOR_MODE_SELECT && BOARD_VREQ && BOARD_LINES == 8'h80)[*3]
        |=> (INT_VEC == 8'h80);
    endproperty
    a_vectored: assert property (p_vectored)
        else $error("board vector not passed through");

    property p_legal;
        @(posedge CLK) disable iff (!RST_N)
        INT_PEND |-> vec_legal(INT_VEC);
    endproperty
    a_legal: assert property (p_legal)
        else $error("reserved vector produced");

    property p_drop;
        @(posedge CLK) disable iff (!RST_N)
        ((SBI_CODE == SB_DBG_RX && MC_CODE == MC_TMR3)[*3]
         ##1 (SBI_CODE == 4'h0 && MC_CODE == MC_TMR3 &&
              !BOARD_INT_ENABLE)[*3])
        |=> (INT_VEC == VEC_TMR3);
    endproperty
    a_drop: assert property (p_drop)
        else $error("dropped request still shown");

endmodule

// file: sim/fpve_cpu_model.sv
// Processor side model that takes vectors off the interrupt bus
`timescale 1ns/1ns
module fpve_cpu_model (
    input  wire logic       clk,        // System clock
    input  wire logic       rst_n,      // Async reset, active low
    input  wire logic [7:0] int_vec,    // Vector bus from encoder
    input  wire logic       int_pend,   // Request pending
    output logic      [7:0] seen_vec_q, // Last vector taken
    output logic      [4:0] seen_lvl_q  // Priority level of that vector
);
    // ========================================================================
    // Vector intake
    // ========================================================================
    logic [7:0] seen_vec_d;             // Next vector taken
    logic [4:0] seen_lvl_d;             // Next level taken

    // Expanded mode: the whole 8-bit vector is read off the bus
    always_comb begin
        seen_vec_d = 8'h00;
        seen_lvl_d = 5'h00;
        if (int_pend) begin
            seen_vec_d = int_vec;
            seen_lvl_d = int_vec[7:3];  // Level is the top five bits
        end
    end

    // Nothing is held once the request is gone, like the real core
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seen_vec_q <= 8'h00;
            seen_lvl_q <= 5'h00;
        end else begin
            seen_vec_q <= seen_vec_d;
            seen_lvl_q <= seen_lvl_d;
        end
    end
endmodule

// file: sim/tb_fixed_priority_vector_encoder.sv
// Self-checking bench for the fixed-priority interrupt vector encoder
`timescale 1ns/1ns
module tb_fixed_priority_vector_encoder;
    import fpve_pkg::*;

    // ========================================================================
    // Pins, counters and vector tables
    // ========================================================================
    logic        clk      = 1'b0;       // 20 MHz clock
    logic        rst_n    = 1'b0;       // Reset, active low
    logic [3:0]  sbi_code = 4'h0;       // System bus chip code
    logic [3:0]  mc_code  = 4'h0;       // Memory controller code
    logic [7:0]  lines    = 8'h00;      // Board lines or board vector
    logic        vreq     = 1'b0;       // Board vector valid
    logic        ben      = 1'b0;       // Board gate
    logic        vmode    = 1'b0;       // Board mode, 1 vectored
    logic [7:0]  int_vec;               // Vector bus
    logic        int_pend;              // Pending flag
    logic [7:0]  cpu_vec;               // Vector seen by processor model
    logic [4:0]  cpu_lvl;               // Level seen by processor model
    logic [15:0] rnd      = 16'h0005;   // Random state
    int          bad_count = 0;         // Mismatches
    int          checked   = 0;         // Comparisons

    // Zero entries mean the code raises nothing
    localparam logic [7:0] MC_TAB [16] = '{8'h00, 8'hff, 8'hfe, 8'hf3,
        8'hf2, 8'hf1, 8'heb, 8'hea, 8'h23, 8'h22, 8'h21, 8'h20, 8'h08,
        8'h00, 8'h00, 8'h00};
    localparam logic [7:0] SB_TAB [16] = '{8'h00, 8'hfd, 8'hd1, 8'hd0,
        8'h64, 8'h63, 8'h62, 8'h61, 8'h60, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00};
    localparam logic [7:0] LINE_TAB [8] = '{8'hd8, 8'hd9, 8'hda, 8'hdb,
        8'he0, 8'he8, 8'hf0, 8'hf8};

    always #25 clk = ~clk;              // 50 ns period

    fpve_top u_dut (
        .CLK                      (clk),
        .RST_N                    (rst_n),
        .SBI_CODE                 (sbi_code),
        .MC_CODE                  (mc_code),
        .BOARD_LINES              (lines),
        .BOARD_VREQ               (vreq),
        .BOARD_INT_ENABLE         (ben),
        .BOARD_VECTOR_MODE_SELECT (vmode),
        .INT_VEC                  (int_vec),
        .INT_PEND                 (int_pend)
    );

    fpve_cpu_model u_cpu (
        .clk        (clk),
        .rst_n      (rst_n),
        .int_vec    (int_vec),
        .int_pend   (int_pend),
        .seen_vec_q (cpu_vec),
        .seen_lvl_q (cpu_lvl)
    );

    // ========================================================================
    // Expectation helpers
    // ========================================================================
    // Valid bit on top, so a plain compare picks the higher vector
    function automatic logic [8:0] max9(input logic [8:0] a,
                                        input logic [8:0] b);
        max9 = (b > a) ? b : a;
    endfunction

    // Vectors a board may hand over; only the reserved gaps are refused
    function automatic logic board_ok(input logic [7:0] v);
        board_ok = v inside {8'hf8, 8'hf0, 8'he8, 8'he0, [8'hd8:8'hdb],
            [8'h80:8'hcf], 8'h7b, 8'h7c, 8'h78, [8'h70:8'h74],
            [8'h40:8'h53], 8'h3a, 8'hff, 8'hfe, 8'hfd, [8'hf1:8'hf3],
            8'heb, 8'hea, 8'hd1, 8'hd0, [8'h60:8'h64], [8'h20:8'h23],
            8'h08};
    endfunction

    // Pending flag and vector for the pins now driven
    function automatic logic [8:0] want();
        logic [8:0] b;
        b = 9'h000;
        if (ben && vmode && vreq && board_ok(lines))
            b = {1'b1, lines};
        for (int i = 0; i < 8; i++)
            if (ben && !vmode && lines[i])
                b = max9(b, {1'b1, LINE_TAB[i]});
        b = max9(b, {|MC_TAB[mc_code], MC_TAB[mc_code]});
        want = max9(b, {|SB_TAB[sbi_code], SB_TAB[sbi_code]});
    endfunction

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // ========================================================================
    // Drivers and checks
    // ========================================================================
    // Result needs three edges through the synchroniser; four are given
    task automatic drive(input logic [3:0] s, input logic [3:0] m,
                         input logic [7:0] l, input logic [2:0] ctl);
        @(posedge clk);
        #2;
        sbi_code = s;
        mc_code = m;
        lines = l;
        {vreq, ben, vmode} = ctl;
        repeat (4) @(posedge clk);
        #2;
    endtask

    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checked %0d bad %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ========================================================================
    // Main sequence
    // ========================================================================
    initial begin
        repeat (16) @(posedge clk);
        #2;
        rst_n = 1'b1;
        repeat (4) @(posedge clk);
        #2;
        chk({int_pend, int_vec}, 9'h000);
        // Every chip code alone, undefined ones included
        for (int c = 0; c < 16; c++) begin
            drive(4'h0, c[3:0], 8'h00, 3'b000);
            chk({int_pend, int_vec}, want());
            drive(c[3:0], 4'h0, 8'h00, 3'b000);
            chk({int_pend, int_vec}, want());
        end
        // Direct lines one at a time, then gated off
        for (int i = 0; i < 8; i++) begin
            drive(4'h0, 4'h0, 8'h01 << i, 3'b010);
            chk({int_pend, int_vec}, want());
            drive(4'h0, 4'h0, 8'h01 << i, 3'b000);
            chk({int_pend, int_vec}, 9'h000);
        end
        // Every board vector against the lowest chip source
        for (int v = 0; v < 256; v++) begin
            drive(4'h0, 4'hc, v[7:0], 3'b111);
            chk({int_pend, int_vec}, want());
        end
        drive(4'h0, 4'h0, 8'hf8, 3'b011);
        chk({int_pend, int_vec}, 9'h000);
        // Board severe fault kept to its own vector
        drive(4'h5, 4'h0, 8'hf8, 3'b111);
        chk({int_pend, int_vec}, 9'h1f8);
        // Everything at once, then sources drop away
        drive(4'h1, 4'hc, 8'hff, 3'b010);
        chk({int_pend, int_vec}, 9'h1fd);
        chk({4'h0, cpu_lvl}, 9'd31);
        drive(4'h0, 4'hc, 8'h00, 3'b010);
        chk({int_pend, int_vec}, 9'h108);
        drive(4'h0, 4'h0, 8'h00, 3'b010);
        chk({int_pend, int_vec}, 9'h000);
        // Corners that the pin-level assertions watch
        drive(4'h8, 4'hc, 8'h00, 3'b000);
        chk({int_pend, int_vec}, 9'h160);
        drive(4'h4, 4'h8, 8'h00, 3'b000);
        chk({int_pend, int_vec}, 9'h164);
        drive(4'h0, 4'h3, 8'hc1, 3'b010);
        chk({int_pend, int_vec}, 9'h1f8);
        drive(4'h0, 4'h9, 8'h80, 3'b111);
        chk({int_pend, int_vec}, 9'h180);
        drive(4'h2, 4'ha, 8'h00, 3'b000);
        chk({int_pend, int_vec}, 9'h1d1);
        drive(4'h0, 4'ha, 8'h00, 3'b000);
        chk({int_pend, int_vec}, 9'h121);
        // Random mixes of all inputs
        repeat (300) begin
            rnd = lfsr(rnd);
            sbi_code = rnd[3:0];
            mc_code = rnd[7:4];
            rnd = lfsr(rnd);
            drive(sbi_code, mc_code, rnd[7:0], rnd[10:8]);
            chk({int_pend, int_vec}, want());
            chk({int_pend, cpu_vec}, want());
        end
        test_done();
    end

    // Whole run needs about 3100 cycles; cut a hang well after that
    initial begin
        #300000;
        bad_count++;
        test_done();
    end
endmodule
